// *** design/hbp_pkg.sv ***
// Constants shared by the host bus port with DMA request
package hbp_pkg;
	localparam int          DATA_W         = 16;   // Width of the parallel data bus
	localparam int          ADDR_W         = 8;    // Width of the register index port
	localparam int          FIFO_DEPTH     = 8;    // Words held between bus and buffer memory
	localparam logic [7:0]  OFS_HOST_SETUP = 8'h20; // Host hardware setup register
	localparam logic [7:0]  OFS_PER_SETUP  = 8'hBA; // Peripheral hardware setup register
	localparam logic [7:0]  OFS_STATUS     = 8'h30; // Port status, read only
	localparam logic [7:0]  OFS_BUF_DATA   = 8'h40; // Buffer memory data window
	localparam int          BIT_REQ_POL    = 0;    // Request active high when set
	localparam int          BIT_ACK_POL    = 1;    // Acknowledge active high when set
	localparam int          BIT_SHARED     = 2;    // Shared DMA channel select (host register)
	localparam logic [15:0] HOST_SETUP_RST = 16'h0000; // Host setup after reset
	localparam logic [15:0] PER_SETUP_RST  = 16'h0000; // Peripheral setup after reset
	localparam logic [15:0] HOST_SETUP_MSK = 16'h0007; // Writable host setup bits
	localparam logic [15:0] PER_SETUP_MSK  = 16'h0003; // Writable peripheral setup bits
	localparam int          ST_EMPTY       = 4;    // Status bit: FIFO empty
	localparam int          ST_FULL        = 5;    // Status bit: FIFO full
	localparam int          ST_DROP        = 6;    // Status bit: write lost on full FIFO
	localparam logic [15:0] ZERO_WORD      = 16'h0000; // Value of unmapped reads
endpackage

// *** design/hbp_port.sv ***
// Host bus port, setup registers, DMA request steering and write FIFO
`timescale 1ns/1ns

// Synchronous FIFO with valid/ready on both sides
module hbp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [WIDTH-1:0]         in_data,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	output logic [WIDTH-1:0]              out_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [$clog2(DEPTH+1)-1:0]    count
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0]           mem [DEPTH];     // Storage array
	logic [PW-1:0]              wr_ptr_q;        // Next slot to fill
	logic [PW-1:0]              rd_ptr_q;        // Next slot to drain
	logic [$clog2(DEPTH+1)-1:0] count_q;         // Words held
	logic                       push;            // Accepted write
	logic                       pop;             // Accepted read

	assign in_ready  = (count_q != ($clog2(DEPTH+1))'(DEPTH));
	assign out_valid = (count_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_q];
	assign count     = count_q;

	// Storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	// Pointers and occupancy
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule

// Processor-facing port of the controller
module hbp_port (
	input  wire logic        clk,                // 25 MHz core clock
	input  wire logic        rst,                // Synchronous reset, active high
	input  wire logic        cs_n,               // Chip select, active low
	input  wire logic        rd_n,               // Read strobe, active low
	input  wire logic        wr_n,               // Write strobe, active low
	input  wire logic [7:0]  reg_addr,           // Register index
	input  wire logic [15:0] data_in,            // Bus level seen by the device
	output logic      [15:0] data_out,           // Read data toward the bus
	output logic      [15:0] data_oe,            // Per line drive enable
	output logic             wr_ready,           // Buffer window can take a word
	output logic      [15:0] buf_wr_data,        // Word toward buffer memory
	output logic             buf_wr_valid,       // Word available
	input  wire logic        buf_wr_ready,       // Buffer memory accepts word
	input  wire logic [15:0] buf_rd_data,        // Word from buffer memory
	output logic             buf_rd_strobe,      // Buffer word consumed by a read
	input  wire logic        host_xfer_need,     // Host controller wants DMA
	input  wire logic        periph_xfer_need,   // Peripheral controller wants DMA
	output logic             host_dma_request,   // Host side DMA request pin
	output logic             periph_dma_request, // Peripheral side DMA request pin
	input  wire logic        host_dma_grant,     // Host side acknowledge pin
	input  wire logic        periph_dma_grant,   // Peripheral side acknowledge pin
	output logic             host_granted,       // Decoded grant to host controller
	output logic             periph_granted      // Decoded grant to peripheral controller
);
	logic [15:0] host_hw_setup_q;   // Host hardware setup
	logic [15:0] periph_hw_setup_q; // Peripheral hardware setup
	logic        rd_n_q;            // Previous read strobe
	logic        wr_n_q;            // Previous write strobe
	logic        rd_start;          // First cycle of a selected read
	logic        wr_start;          // First cycle of a selected write
	logic        reading;           // Selected read in progress
	logic        drop_q;            // Sticky lost write flag
	logic        fifo_push;         // Write to buffer window
	logic [3:0]  fifo_count;        // FIFO occupancy
	logic        shared;            // Both channels on host pins
	logic        host_need;         // Request seen on host pin
	logic        per_need;          // Request seen on peripheral pin
	logic        host_ack;          // Host pin acknowledge decoded
	logic        per_ack;           // Peripheral pin acknowledge decoded
	logic [15:0] rd_word;           // Read mux result
	logic [15:0] status_word;       // Status register image

	// Read decode: selected register or zero when unmapped
	function automatic logic [15:0] read_mux(input logic [7:0] a, input logic [15:0] hs,
		input logic [15:0] ps, input logic [15:0] st, input logic [15:0] bd);
		unique case (a)
			hbp_pkg::OFS_HOST_SETUP: read_mux = hs;
			hbp_pkg::OFS_PER_SETUP:  read_mux = ps;
			hbp_pkg::OFS_STATUS:     read_mux = st;
			hbp_pkg::OFS_BUF_DATA:   read_mux = bd;
			default:                 read_mux = hbp_pkg::ZERO_WORD;
		endcase
	endfunction

	// Strobes count only under chip select
	assign reading  = !cs_n && !rd_n;
	assign rd_start = reading && rd_n_q;
	assign wr_start = !cs_n && !wr_n && wr_n_q;
	assign fifo_push = wr_start && (reg_addr == hbp_pkg::OFS_BUF_DATA);

	// Bus driven only while a selected read is under way
	assign data_oe = {16{reading}};

	// Strobe history for edge detection
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
		end
		else
		begin
			rd_n_q <= rd_n;
			wr_n_q <= wr_n;
		end
	end

	// Setup register writes, masked to implemented bits
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			host_hw_setup_q   <= hbp_pkg::HOST_SETUP_RST;
			periph_hw_setup_q <= hbp_pkg::PER_SETUP_RST;
		end
		else if (wr_start && reg_addr == hbp_pkg::OFS_HOST_SETUP)
			host_hw_setup_q <= data_in & hbp_pkg::HOST_SETUP_MSK;
		else if (wr_start && reg_addr == hbp_pkg::OFS_PER_SETUP)
			periph_hw_setup_q <= data_in & hbp_pkg::PER_SETUP_MSK;
	end

	// Lost write flag; a read of status clears it, a new loss wins
	always_ff @(posedge clk)
	begin
		if (rst)
			drop_q <= 1'b0;
		else if (fifo_push && !wr_ready)
			drop_q <= 1'b1;
		else if (rd_start && reg_addr == hbp_pkg::OFS_STATUS)
			drop_q <= 1'b0;
	end

	// Status word built from FIFO state at the named bit positions
	always_comb
	begin
		status_word                   = hbp_pkg::ZERO_WORD;
		status_word[3:0]              = fifo_count;
		status_word[hbp_pkg::ST_EMPTY] = (fifo_count == 4'h0);
		status_word[hbp_pkg::ST_FULL]  = !wr_ready;
		status_word[hbp_pkg::ST_DROP]  = drop_q;
		rd_word = read_mux(reg_addr, host_hw_setup_q, periph_hw_setup_q,
			status_word, buf_rd_data);
	end

	// Read data register, refreshed every cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			data_out <= hbp_pkg::ZERO_WORD;
		else
			data_out <= rd_word;
	end

	// Buffer read consumption pulse
	always_ff @(posedge clk)
	begin
		if (rst)
			buf_rd_strobe <= 1'b0;
		else
			buf_rd_strobe <= rd_start && (reg_addr == hbp_pkg::OFS_BUF_DATA);
	end

	// Write FIFO between bus and buffer memory
	hbp_fifo #(
		.WIDTH (hbp_pkg::DATA_W),
		.DEPTH (hbp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (data_in),
		.in_valid  (fifo_push),
		.in_ready  (wr_ready),
		.out_data  (buf_wr_data),
		.out_valid (buf_wr_valid),
		.out_ready (buf_wr_ready),
		.count     (fifo_count)
	);

	// DMA steering: shared mode folds peripheral onto host pins
	assign shared    = host_hw_setup_q[hbp_pkg::BIT_SHARED];
	assign host_need = host_xfer_need || (shared && periph_xfer_need);
	assign per_need  = !shared && periph_xfer_need;
	assign host_ack  = (host_dma_grant == host_hw_setup_q[hbp_pkg::BIT_ACK_POL]);
	assign per_ack   = (periph_dma_grant == periph_hw_setup_q[hbp_pkg::BIT_ACK_POL]);

	// Request pins registered at programmed polarity
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			host_dma_request   <= !hbp_pkg::HOST_SETUP_RST[hbp_pkg::BIT_REQ_POL];
			periph_dma_request <= !hbp_pkg::PER_SETUP_RST[hbp_pkg::BIT_REQ_POL];
		end
		else
		begin
			host_dma_request   <= host_need ~^ host_hw_setup_q[hbp_pkg::BIT_REQ_POL];
			periph_dma_request <= per_need ~^ periph_hw_setup_q[hbp_pkg::BIT_REQ_POL];
		end
	end

	// Grant decode; in shared mode the host pin grants both
	assign host_granted   = host_ack;
	assign periph_granted = shared ? host_ack : per_ack;

	// Bus drive tied to a selected read
	property p_bus_drive;
		@(posedge clk) disable iff (rst)
		(data_oe != 16'h0000) |-> (!cs_n && !rd_n);
	endproperty
	a_bus_drive: assert property (p_bus_drive)
		else $error("data bus driven outside a read");

	// No effect from strobes without chip select
	property p_no_select;
		@(posedge clk) disable iff (rst)
		cs_n |-> (data_oe == 16'h0000) && !fifo_push ##1 $stable(host_hw_setup_q);
	endproperty
	a_no_select: assert property (p_no_select)
		else $error("strobe acted without chip select");

	// Host request follows need with programmed level one cycle later
	property p_host_req;
		@(posedge clk) disable iff (rst)
		host_xfer_need ##0 $stable(host_hw_setup_q) ##1 $stable(host_hw_setup_q)
		|-> host_dma_request == host_hw_setup_q[hbp_pkg::BIT_REQ_POL];
	endproperty
	a_host_req: assert property (p_host_req)
		else $error("host request not raised");

	// Idle host request sits at inactive level
	property p_host_pol;
		@(posedge clk) disable iff (rst)
		(!host_xfer_need && !periph_xfer_need) ##1 $stable(host_hw_setup_q)
		|-> host_dma_request != host_hw_setup_q[hbp_pkg::BIT_REQ_POL];
	endproperty
	a_host_pol: assert property (p_host_pol)
		else $error("host request at wrong level");

	// Shared mode: peripheral need appears on host pin, peripheral pin idle
	property p_shared;
		@(posedge clk) disable iff (rst)
		(shared && periph_xfer_need)
		##1 ($stable(host_hw_setup_q) && $stable(periph_hw_setup_q)) |->
		host_dma_request == host_hw_setup_q[hbp_pkg::BIT_REQ_POL] &&
		periph_dma_request != periph_hw_setup_q[hbp_pkg::BIT_REQ_POL];
	endproperty
	a_shared: assert property (p_shared)
		else $error("shared routing wrong");

	// Peripheral request at its own programmed level when not shared
	property p_per_req;
		@(posedge clk) disable iff (rst)
		(!shared && periph_xfer_need) ##1 ($stable(host_hw_setup_q) && $stable(periph_hw_setup_q))
		|-> periph_dma_request == periph_hw_setup_q[hbp_pkg::BIT_REQ_POL];
	endproperty
	a_per_req: assert property (p_per_req)
		else $error("peripheral request not raised");
endmodule

// *** verif/hbp_dma_model.sv ***
// Behavioural DMA controller that grants host side requests
`timescale 1ns/1ns

module hbp_dma_model (
	input  wire logic clk,      // Core clock
	input  wire logic rst,      // Synchronous reset
	input  wire logic req,      // Host side request pin
	input  wire logic req_pol,  // Request active level
	input  wire logic ack_pol,  // Acknowledge active level
	output logic      grant     // Host side acknowledge pin
);
	// Grant one cycle after an active request, idle level otherwise
	always_ff @(posedge clk)
	begin
		if (rst)
			grant <= ~ack_pol;
		else if (req == req_pol)
			grant <= ack_pol;
		else
			grant <= ~ack_pol;
	end
endmodule

// *** verif/hbp_port_bench.sv ***
// Self-checking bench for the host bus port
`timescale 1ns/1ns

module hbp_port_bench;
	logic        clk = 1'b0;       // Core clock
	logic        rst = 1'b1;       // Reset
	logic        cs_n = 1'b1;      // Chip select
	logic        rd_n = 1'b1;      // Read strobe
	logic        wr_n = 1'b1;      // Write strobe
	logic [7:0]  reg_addr = 8'h00; // Register index
	logic [15:0] bus_drv = 16'h0000; // Processor side bus value
	logic [15:0] data_in;          // Resolved bus
	logic [15:0] data_out;         // Device read data
	logic [15:0] data_oe;          // Device drive enables
	logic        wr_ready;         // FIFO space
	logic [15:0] buf_wr_data;      // FIFO head
	logic        buf_wr_valid;     // FIFO not empty
	logic        buf_wr_ready = 1'b0; // Buffer memory pop
	logic        host_need = 1'b0; // Host controller need
	logic        per_need = 1'b0;  // Peripheral controller need
	logic        host_req;         // Host request pin
	logic        per_req;          // Peripheral request pin
	logic        host_grant;       // Host acknowledge pin
	logic        per_grant = 1'b1; // Peripheral acknowledge pin
	logic        host_granted;     // Decoded host grant
	logic        per_granted;      // Decoded peripheral grant
	logic        pol = 1'b0;       // Programmed request and grant level
	logic [15:0] rd_val;           // Last read value
	logic [15:0] buf_rd_word = 16'h5A5A; // Word shown at the buffer window
	logic        rd_strobe;        // Buffer read consumption pulse
	int          rd_pulses = 0;    // Buffer read pulses counted
	int          err_count = 0;    // Mismatches
	int          checks_done = 0;  // Comparisons

	// Clock of 40 ns
	always #20 clk = ~clk;

	// Wire resolution of the data bus
	assign data_in = (data_oe & data_out) | (~data_oe & bus_drv);

	// Count buffer read pulses
	always @(posedge clk)
	begin
		if (rd_strobe === 1'b1)
			rd_pulses <= rd_pulses + 1;
	end

	hbp_port u_hbp_port (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.reg_addr(reg_addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.wr_ready(wr_ready), .buf_wr_data(buf_wr_data), .buf_wr_valid(buf_wr_valid),
		.buf_wr_ready(buf_wr_ready), .buf_rd_data(buf_rd_word), .buf_rd_strobe(rd_strobe),
		.host_xfer_need(host_need), .periph_xfer_need(per_need),
		.host_dma_request(host_req), .periph_dma_request(per_req),
		.host_dma_grant(host_grant), .periph_dma_grant(per_grant),
		.host_granted(host_granted), .periph_granted(per_granted));

	hbp_dma_model u_hbp_dma_model (.clk(clk), .rst(rst), .req(host_req), .req_pol(pol),
		.ack_pol(pol), .grant(host_grant));

	// Compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic close_out();
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Write cycle, strobe low for one cycle then high for one
	task automatic bus_write(input logic [7:0] a, input logic [15:0] d, input logic sel_n);
		cs_n = sel_n;
		wr_n = 1'b0;
		reg_addr = a;
		bus_drv = d;
		@(negedge clk);
		cs_n = 1'b1;
		wr_n = 1'b1;
		bus_drv = ~d;
		@(negedge clk);
	endtask

	// Read cycle, data sampled one edge after the strobe falls
	task automatic bus_read(input logic [7:0] a);
		cs_n = 1'b0;
		rd_n = 1'b0;
		reg_addr = a;
		#1 check("oe_read", data_oe, 16'hFFFF);
		@(negedge clk);
		rd_val = data_out;
		cs_n = 1'b1;
		rd_n = 1'b1;
		#1 check("oe_idle", data_oe, 16'h0000);
		@(negedge clk);
	endtask

	// Reset values and unmapped read
	task automatic t_reset();
		bus_read(hbp_pkg::OFS_HOST_SETUP);
		check("host_setup", rd_val, hbp_pkg::HOST_SETUP_RST);
		bus_read(8'h00);
		check("unmapped", rd_val, hbp_pkg::ZERO_WORD);
		bus_read(hbp_pkg::OFS_BUF_DATA);
		check("buf_word", rd_val, 16'h5A5A);
		check("buf_strobe", 16'(rd_pulses), 16'h0001);
		check("host_req", {15'h0000, host_req}, 16'h0001);
	endtask

	// Polarity high, request and grant follow need
	task automatic t_polarity();
		bus_write(hbp_pkg::OFS_HOST_SETUP, 16'hFFF3, 1'b0);
		bus_read(hbp_pkg::OFS_HOST_SETUP);
		check("setup_mask", rd_val, 16'h0003);
		pol = 1'b1;
		host_need = 1'b1;
		repeat (2) @(negedge clk);
		check("req_on", {15'h0000, host_req}, 16'h0001);
		check("granted", {15'h0000, host_granted}, 16'h0001);
		host_need = 1'b0;
		repeat (2) @(negedge clk);
		check("req_off", {15'h0000, host_req}, 16'h0000);
		check("grant_off", {15'h0000, host_granted}, 16'h0000);
	endtask

	// Strobes without select change nothing and leave the bus floating
	task automatic t_no_select();
		reg_addr = hbp_pkg::OFS_BUF_DATA;
		rd_n = 1'b0;
		#1 check("oe_nosel", data_oe, 16'h0000);
		@(negedge clk);
		rd_n = 1'b1;
		bus_write(hbp_pkg::OFS_HOST_SETUP, 16'h0000, 1'b1);
		bus_read(hbp_pkg::OFS_HOST_SETUP);
		check("setup_kept", rd_val, 16'h0003);
		check("nosel_strobe", 16'(rd_pulses), 16'h0001);
	endtask

	// Shared channel routes peripheral need onto host pins
	task automatic t_shared();
		bus_write(hbp_pkg::OFS_PER_SETUP, 16'h0001, 1'b0);
		bus_write(hbp_pkg::OFS_HOST_SETUP, 16'h0007, 1'b0);
		per_need = 1'b1;
		repeat (2) @(negedge clk);
		check("sh_host", {15'h0000, host_req}, 16'h0001);
		check("sh_per", {15'h0000, per_req}, 16'h0000);
		check("sh_grant", {15'h0000, per_granted}, 16'h0001);
		bus_write(hbp_pkg::OFS_HOST_SETUP, 16'h0003, 1'b0);
		repeat (2) @(negedge clk);
		check("per_req", {15'h0000, per_req}, 16'h0001);
		check("per_grant_off", {15'h0000, per_granted}, 16'h0000);
		per_grant = 1'b0;
		@(negedge clk);
		check("per_grant_on", {15'h0000, per_granted}, 16'h0001);
		per_need = 1'b0;
	endtask

	// Fill FIFO past full, then drain it
	task automatic t_fifo();
		int n;
		for (n = 0; n < 9; n++)
			bus_write(hbp_pkg::OFS_BUF_DATA, 16'h0A00 + 16'(n), 1'b0);
		check("wr_ready", {15'h0000, wr_ready}, 16'h0000);
		check("head", buf_wr_data, 16'h0A00);
		bus_read(hbp_pkg::OFS_STATUS);
		check("st_full", rd_val, 16'h0068);
		buf_wr_ready = 1'b1;
		n = 0;
		while (buf_wr_valid !== 1'b0 && n < 20)
		begin
			check("drain_data", buf_wr_data, 16'h0A00 + 16'(n));
			@(negedge clk);
			n++;
		end
		if (n == 20)
		begin
			check("drain", 16'h0000, 16'h0001);
			close_out();
		end
		else
		begin
			check("drain_count", 16'(n), 16'h0008);
			bus_read(hbp_pkg::OFS_STATUS);
			check("st_empty", rd_val, 16'h0010);
		end
	endtask

	// Main sequence
	initial
	begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_polarity();
		t_no_select();
		t_shared();
		t_fifo();
		close_out();
	end
endmodule
